/* fbsec_consts.vh */
// constants for the boot-sector protection and sector erase controller
// assumes inclusion by bare name from the design files
`ifndef FBSEC_CONSTS_VH
`define FBSEC_CONSTS_VH
// register word offsets (byte address = offset, aligned words)
`define FBSEC_OFF_UNLOCK 4'h0
`define FBSEC_OFF_SECHI 4'h4
`define FBSEC_OFF_SECLO 4'h8
`define FBSEC_OFF_CTRL 4'hC
// unlock and control codes
`define FBSEC_UNLOCK_KEY 8'hA5
`define FBSEC_CTRL_ERASE 8'hA1
`define FBSEC_CTRL_OFF 8'h00
`define FBSEC_FAIL_BIT 3
`define FBSEC_BUSY_BIT 7
`define FBSEC_RST_BYTE 8'h00
// configuration word fields
`define FBSEC_VEC_HI 7
`define FBSEC_VEC_LO 5
`define FBSEC_SIZE_HI 2
`define FBSEC_SIZE_LO 0
`define FBSEC_AREA_BASE 16'h0100
`define FBSEC_VEC_NONE 16'h0100
`define FBSEC_VEC_SEL0 16'h0200
`define FBSEC_VEC_SEL1 16'h0300
`define FBSEC_VEC_SEL2 16'h0400
`define FBSEC_VEC_SEL3 16'h0500
`define FBSEC_END_SIZE0 16'h01FF
`define FBSEC_END_SIZE1 16'h02FF
`define FBSEC_END_SIZE2 16'h04FF
`define FBSEC_END_SIZE3 16'h08FF
// configuration capture: value before capture, edges waited after reset
`define FBSEC_CFG_UNSET 8'hFF
`define FBSEC_CFG_WAIT 2'h2
// sector geometry
`define FBSEC_SECT_LSB 7
`define FBSEC_SECT_COUNT 384
// erase time
`define FBSEC_ERASE_MS 10
`define FBSEC_CLK_KHZ 125000
`endif

/* fbsec_area_decode.v */
// boot area decoder: configuration word to reset vector and protected limit
// assumes a stable configuration word from the same clock domain
`timescale 1ns/1ps
`include "fbsec_consts.vh"
module fbsec_area_decode (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clkEn,
  // configuration
  input wire [7:0] cfgWord,
  // decoded values
  output reg [15:0] resetVector,
  output reg [15:0] areaEnd,
  output reg areaSized
);
  wire [2:0] vecSel;
  wire [2:0] sizeSel;
  reg [15:0] next_vector;
  reg [15:0] next_end;
  assign vecSel = cfgWord[`FBSEC_VEC_HI:`FBSEC_VEC_LO];
  assign sizeSel = cfgWord[`FBSEC_SIZE_HI:`FBSEC_SIZE_LO];
  // two fields decoded apart
  always @* begin
    next_vector = `FBSEC_VEC_NONE;
    case (vecSel)
      3'h0: next_vector = `FBSEC_VEC_SEL0;
      3'h1: next_vector = `FBSEC_VEC_SEL1;
      3'h2: next_vector = `FBSEC_VEC_SEL2;
      3'h3: next_vector = `FBSEC_VEC_SEL3;
      default: next_vector = `FBSEC_VEC_NONE;
    endcase
  end
  always @* begin
    next_end = `FBSEC_AREA_BASE;
    case (sizeSel)
      3'h0: next_end = `FBSEC_END_SIZE0;
      3'h1: next_end = `FBSEC_END_SIZE1;
      3'h2: next_end = `FBSEC_END_SIZE2;
      3'h3: next_end = `FBSEC_END_SIZE3;
      default: next_end = `FBSEC_AREA_BASE;
    endcase
  end
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetVector <= `FBSEC_VEC_NONE;
      areaEnd <= `FBSEC_AREA_BASE;
      areaSized <= 1'b0;
    end else if (clkEn) begin
      resetVector <= next_vector;
      areaEnd <= next_end;
      areaSized <= ~sizeSel[2];
    end
  end
endmodule // fbsec_area_decode

/* fbsec_ctrl.v */
// boot-sector protection and user-mode sector erase controller
// assumes an Avalon-MM master on ref_clk and asynchronous mode pins
// What this block does
// - refuse load-instruction writes into active boot area
// - protection only when enable bit reads zero
// - tool mode may program boot area, but not erase it
// - vector bits select power-on reset vector
// - size bits select protected area from 100h
// - vector and size fields decoded independently
// - erase only in user mode, whole sectors
// - 384 sectors of 128 bytes each (code does not bound the 9-bit sector number, so 512 can be selected)
// - erase lasts at least 10 ms
// - no sector erase in tool or emulator mode
// - unmasked interrupt may stop an erase
// - A1h to control while unlocked starts erase
// - control bit 3 reports erase failure
// - zero to control leaves erase mode
// - unlock only when register holds A5h
// - high byte bits 15:8, low bit 7
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "fbsec_consts.vh"
module fbsec_ctrl #(
  parameter integer ERASE_CYCLES = `FBSEC_ERASE_MS * `FBSEC_CLK_KHZ
) (
  // clock, enable and reset
  input wire ref_clk,
  input wire clkEn,
  input wire rst_b,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // configuration word and mode pins
  input wire [7:0] cfgWord,
  input wire bootAreaDisable,
  input wire toolMode,
  input wire emulatorMode,
  // interrupt stop request from the core
  input wire irqPending,
  // program-memory write request from the load instruction
  input wire loadWrReq,
  input wire [15:0] loadWrAddr,
  output reg loadWrGrant,
  output reg loadWrDeny,
  // flash array erase port
  output reg eraseActive,
  output reg [15:0] eraseBase,
  // decoded reset vector
  output reg [15:0] resetVector
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ERASE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;
  localparam integer CW = 32;
  // input synchronisers
  reg [3:0] pinMeta;
  reg [3:0] pinSync;
  reg [7:0] cfgMeta;
  reg [7:0] cfgSync;
  reg [7:0] cfgLatched;
  reg [1:0] cfgAge;
  reg cfgTaken;
  // registers
  reg [7:0] unlockReg;
  reg [7:0] secHi;
  reg [7:0] secLo;
  reg [7:0] ctrlReg;
  reg eraseFail;
  reg [1:0] state;
  reg [CW-1:0] eraseCount;
  reg accDone;
  wire [15:0] vecOut;
  wire [15:0] areaEnd;
  wire areaSized;
  wire bootOff;
  wire toolSync;
  wire emuSync;
  wire irqSync;
  wire userUnlocked;
  wire protectOn;
  wire [15:0] sectorBase;
  wire baseInArea;
  wire loadInArea;
  wire wrHit;
  wire rdHit;
  wire startErase;
  wire stopCtrl;
  assign bootOff = pinSync[0];
  assign toolSync = pinSync[1];
  assign emuSync = pinSync[2];
  assign irqSync = pinSync[3];
  assign userUnlocked = (unlockReg == `FBSEC_UNLOCK_KEY);
  assign protectOn = areaSized & ~bootOff;
  // sector base from high byte and bit 7 of low byte
  assign sectorBase = {secHi, secLo[`FBSEC_SECT_LSB], 7'h00};
  assign baseInArea = protectOn && (sectorBase >= `FBSEC_AREA_BASE) &&
                      (sectorBase <= areaEnd);
  assign loadInArea = protectOn && (loadWrAddr >= `FBSEC_AREA_BASE) &&
                      (loadWrAddr <= areaEnd);
  assign wrHit = avs_write & avs_waitrequest & ~accDone;
  assign rdHit = avs_read & avs_waitrequest & ~accDone;
  assign startErase = wrHit && (avs_address == `FBSEC_OFF_CTRL) &&
                      (avs_writedata[7:0] == `FBSEC_CTRL_ERASE) &&
                      userUnlocked;
  assign stopCtrl = wrHit && (avs_address == `FBSEC_OFF_CTRL) &&
                    (avs_writedata[7:0] == `FBSEC_CTRL_OFF);
  fbsec_area_decode u_decode (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .cfgWord(cfgLatched),
    .resetVector(vecOut),
    .areaEnd(areaEnd),
    .areaSized(areaSized)
  );
  // two-stage synchronisers on pins
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      cfgMeta <= `FBSEC_RST_BYTE;
      cfgSync <= `FBSEC_RST_BYTE;
    end else if (clkEn) begin
      pinMeta <= {irqPending, emulatorMode, toolMode, bootAreaDisable};
      pinSync <= pinMeta;
      cfgMeta <= cfgWord;
      cfgSync <= cfgMeta;
    end
  end
  // configuration word captured once, after the synchroniser has filled
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgLatched <= `FBSEC_CFG_UNSET;
      cfgAge <= 2'h0;
      cfgTaken <= 1'b0;
    end else if (clkEn && !cfgTaken) begin
      if (cfgAge == `FBSEC_CFG_WAIT) begin
        cfgLatched <= cfgSync;
        cfgTaken <= 1'b1;
      end else begin
        cfgAge <= cfgAge + 2'h1;
      end
    end
  end
  // avalon slave: one wait cycle per access
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      accDone <= 1'b0;
    end else if (clkEn) begin
      if (accDone) begin
        avs_waitrequest <= 1'b1;
        accDone <= 1'b0;
      end else if (avs_read | avs_write) begin
        avs_waitrequest <= 1'b0;
        accDone <= 1'b1;
      end
      if (rdHit) begin
        case (avs_address)
          `FBSEC_OFF_UNLOCK: avs_readdata <= {24'h000000, unlockReg};
          `FBSEC_OFF_SECHI: avs_readdata <= {24'h000000, secHi};
          `FBSEC_OFF_SECLO: avs_readdata <= {24'h000000, secLo};
          `FBSEC_OFF_CTRL: avs_readdata <= {24'h000000, ctrlReg};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // register writes
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      unlockReg <= `FBSEC_RST_BYTE;
      secHi <= `FBSEC_RST_BYTE;
      secLo <= `FBSEC_RST_BYTE;
    end else if (clkEn && wrHit) begin
      case (avs_address)
        `FBSEC_OFF_UNLOCK: unlockReg <= avs_writedata[7:0];
        `FBSEC_OFF_SECHI: secHi <= avs_writedata[7:0];
        `FBSEC_OFF_SECLO: secLo <= avs_writedata[7:0];
        default: unlockReg <= unlockReg;
      endcase
    end
  end
  // erase sequencer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      eraseCount <= {CW{1'b0}};
      eraseFail <= 1'b0;
      eraseActive <= 1'b0;
      eraseBase <= 16'h0000;
      ctrlReg <= `FBSEC_RST_BYTE;
    end else if (clkEn) begin
      case (state)
        ST_IDLE: begin
          if (startErase) begin
            if (toolSync || emuSync) begin
              eraseFail <= 1'b1;
            end else if (baseInArea) begin
              eraseFail <= 1'b1;
            end else begin
              eraseFail <= 1'b0;
              eraseActive <= 1'b1;
              eraseBase <= sectorBase;
              eraseCount <= ERASE_CYCLES[CW-1:0];
              state <= ST_ERASE;
            end
            ctrlReg <= `FBSEC_CTRL_ERASE;
          end else if (stopCtrl) begin
            ctrlReg <= `FBSEC_CTRL_OFF;
            eraseFail <= 1'b0;
          end else if (wrHit && avs_address == `FBSEC_OFF_CTRL) begin
            ctrlReg <= avs_writedata[7:0];
          end
        end
        ST_ERASE: begin
          if (irqSync || stopCtrl) begin
            eraseActive <= 1'b0;
            eraseFail <= 1'b1;
            state <= ST_DONE;
          end else if (eraseCount <= {{(CW-1){1'b0}}, 1'b1}) begin
            eraseActive <= 1'b0;
            state <= ST_DONE;
          end else begin
            eraseCount <= eraseCount - {{(CW-1){1'b0}}, 1'b1};
          end
        end
        ST_DONE: begin
          if (stopCtrl) begin
            ctrlReg <= `FBSEC_CTRL_OFF;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (state != ST_IDLE || !startErase) begin
        ctrlReg[`FBSEC_FAIL_BIT] <= eraseFail;
        ctrlReg[`FBSEC_BUSY_BIT] <= (state == ST_ERASE);
      end
    end
  end
  // load-instruction write gate
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loadWrGrant <= 1'b0;
      loadWrDeny <= 1'b0;
      resetVector <= `FBSEC_VEC_NONE;
    end else if (clkEn) begin
      resetVector <= vecOut;
      if (loadWrReq) begin
        if (toolSync) begin
          loadWrGrant <= 1'b1;
          loadWrDeny <= 1'b0;
        end else if (loadInArea || !userUnlocked) begin
          loadWrGrant <= 1'b0;
          loadWrDeny <= 1'b1;
        end else begin
          loadWrGrant <= 1'b1;
          loadWrDeny <= 1'b0;
        end
      end else begin
        loadWrGrant <= 1'b0;
        loadWrDeny <= 1'b0;
      end
    end
  end
endmodule // fbsec_ctrl

/* fbsec_ctrl_chk.sv */
// checker for the boot-area protection and sector erase controller
// assumes a bind to fbsec_ctrl and one clock domain
`timescale 1ns/1ps
module fbsec_ctrl_chk #(
  parameter integer ERASE_CYCLES = 20
) (
  // clock, enable and reset
  input wire ref_clk,
  input wire clkEn,
  input wire rst_b,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // configuration and modes
  input wire [7:0] cfgWord,
  input wire bootAreaDisable,
  input wire toolMode,
  input wire emulatorMode,
  input wire irqPending,
  // load writes
  input wire loadWrReq,
  input wire [15:0] loadWrAddr,
  input wire loadWrGrant,
  input wire loadWrDeny,
  // erase and vector
  input wire eraseActive,
  input wire [15:0] eraseBase,
  input wire [15:0] resetVector
);
  reg [7:0] unl, secHi, secLo;
  reg [3:0] upCnt;
  reg [2:0] qCnt, pinsQ;
  reg [20:0] actCnt;
  reg aborted;
  wire wrDone = avs_write && !avs_waitrequest;
  wire [7:0] wd = avs_writedata[7:0];
  wire [15:0] base = {secHi, secLo[7], 7'h00};
  function automatic prot(input [15:0] a);
    prot = !bootAreaDisable && !cfgWord[2] && a >= 16'h0100
      && a <= 16'h00FF + (16'h0100 << cfgWord[1:0]);
  endfunction
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {unl, secHi, secLo, upCnt, qCnt, pinsQ, actCnt, aborted} <= 56'h0;
    end else begin
      upCnt <= (upCnt == 4'hF) ? upCnt : upCnt + 4'h1;
      pinsQ <= {bootAreaDisable, toolMode, emulatorMode};
      qCnt <= (pinsQ != {bootAreaDisable, toolMode, emulatorMode}) ? 3'h0 :
        (qCnt == 3'h7) ? qCnt : qCnt + 3'h1;
      if (wrDone && avs_address == 4'h0) unl <= wd;
      if (wrDone && avs_address == 4'h4) secHi <= wd;
      if (wrDone && avs_address == 4'h8) secLo <= wd;
      actCnt <= eraseActive ? actCnt + 21'h1 : 21'h0;
      aborted <= eraseActive && (aborted || irqPending || (avs_write && avs_waitrequest
        && avs_address == 4'hC && wd == 8'h00));
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence startWr;
    wrDone && avs_address == 4'hC && wd == 8'hA1 && !$past(eraseActive) && qCnt == 3'h7;
  endsequence
  sequence startOk;
    startWr ##0 (unl == 8'hA5 && !toolMode && !emulatorMode && !prot(base));
  endsequence
  sequence startBad;
    startWr ##0 (unl != 8'hA5 || toolMode || emulatorMode || prot(base));
  endsequence
  wire loadHeld = loadWrReq && qCnt == 3'h7;
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait");
  answer_time_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("answer");
  vector_decode_a: assert property (upCnt == 4'hF && !bootAreaDisable |->
    resetVector == (cfgWord[7] ? 16'h0100 : {6'h00, cfgWord[6:5], 8'h00} + 16'h0200))
    else $error("vector");
  boot_deny_a: assert property (loadHeld && $past(loadWrReq) && $stable(loadWrAddr)
    && !toolMode && prot(loadWrAddr) |-> loadWrDeny && !loadWrGrant) else $error("deny");
  tool_grant_a: assert property (loadHeld && $past(loadWrReq) && $stable(loadWrAddr)
    && toolMode |-> loadWrGrant) else $error("tool");
  open_grant_a: assert property (loadHeld && $past(loadWrReq) && $stable(loadWrAddr)
    && unl == 8'hA5 && !prot(loadWrAddr) |-> loadWrGrant) else $error("grant");
  erase_start_a: assert property (startOk |-> ##[0:1] eraseActive) else $error("start");
  erase_refuse_a: assert property (startBad |-> !eraseActive ##1 !eraseActive [*3])
    else $error("refuse");
  erase_base_a: assert property ($rose(eraseActive) |-> eraseBase == base)
    else $error("base");
  erase_len_a: assert property ($fell(eraseActive) && !aborted |->
    actCnt >= ERASE_CYCLES) else $error("length");
  irq_abort_a: assert property (eraseActive && irqPending |-> ##[1:4] !eraseActive)
    else $error("irq");
  zero_abort_a: assert property ($past(eraseActive) && wrDone && avs_address == 4'hC
    && wd == 8'h00 |-> ##[0:2] !eraseActive) else $error("zero");
endmodule // fbsec_ctrl_chk
bind fbsec_ctrl fbsec_ctrl_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.*);

/* fbsec_ctrl_tb_top.sv */
// self-checking testbench for the boot-area protection and erase controller
// assumes the checker is bound to the design
`timescale 1ns/1ps
module fbsec_ctrl_tb_top;
  reg ref_clk = 1'h0, clkEn = 1'h1, rst_b = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  reg [3:0] avs_address = 4'h0;
  reg [31:0] avs_writedata = 32'h0, rd;
  reg [7:0] cfgWord = 8'h03;
  reg bootAreaDisable = 1'h0, toolMode = 1'h0, emulatorMode = 1'h0;
  reg irqPending = 1'h0, loadWrReq = 1'h0;
  reg [15:0] loadWrAddr = 16'h0, e;
  reg [2:0] v, s;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, loadWrGrant, loadWrDeny, eraseActive;
  wire [15:0] eraseBase, resetVector;
  integer miscompares = 0, n_checks = 0, k;
  fbsec_ctrl #(.ERASE_CYCLES(20)) dut (.*);
  initial forever #4 ref_clk = ~ref_clk;
  task end_of_test;
    begin
      if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task bus(input wr, input [3:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      if (!wr) rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
    end
  endtask
  task rstc(input [7:0] c);
    begin
      rst_b <= 1'h0;
      cfgWord <= c;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'h1;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  task pins(input b, input t, input m);
    begin
      bootAreaDisable <= b;
      toolMode <= t;
      emulatorMode <= m;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  task ldw(input [15:0] a, input g);
    begin
      @(posedge ref_clk);
      loadWrAddr <= a;
      loadWrReq <= 1'h1;
      repeat (3) @(posedge ref_clk);
      chk({loadWrGrant, loadWrDeny}, {g, !g});
      loadWrReq <= 1'h0;
    end
  endtask
  task erz(input [7:0] h, input [7:0] l, input f);
    integer n;
    begin
      bus(1, 4'h0, 8'hA5);
      bus(1, 4'h4, h);
      bus(1, 4'h8, l);
      bus(1, 4'hC, 8'hA1);
      @(posedge ref_clk);
      chk(eraseActive, !f);
      if (!f) chk(eraseBase, {h, l[7], 7'h00});
      n = 0;
      while (eraseActive === 1'b1) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (!f) chk(n >= 19, 1);
      bus(0, 4'hC, 8'h00);
      chk(rd[3], f);
      chk(rd[7], 0);
      bus(1, 4'h0, 8'h00);
    end
  endtask
  initial begin
    #100000;
    miscompares = miscompares + 1;
    end_of_test;
  end
  initial begin
    for (k = 0; k < 5; k = k + 1) begin
      v = (k == 0) ? 3'h4 : 3'(k - 1);
      s = (k == 4) ? 3'h4 : 3'(3 - k);
      e = 16'h00FF + (16'h0100 << s[1:0]);
      rstc({v, 2'h0, s});
      chk(resetVector, 32'h100 + 32'h100 * k);
      bus(1, 4'h0, 8'hA5);
      ldw(16'h00FF, 1);
      if (s[2]) ldw(16'h0100, 1);
      else ldw(e, 0);
      if (!s[2]) ldw(e + 16'h1, 1);
      bus(1, 4'h0, 8'h00);
    end
    rstc(8'h03);
    erz(8'h09, 8'h7F, 0);
    erz(8'h10, 8'hFF, 0);
    erz(8'h08, 8'h80, 1);
    bus(1, 4'h0, 8'hA5);
    bus(1, 4'h4, 8'h10);
    bus(1, 4'hC, 8'hA1);
    repeat (2) @(posedge ref_clk);
    irqPending <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk(eraseActive, 0);
    irqPending <= 1'h0;
    bus(0, 4'hC, 8'h00);
    chk(rd[3], 1);
    bus(1, 4'hC, 8'hA1);
    bus(1, 4'hC, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk(eraseActive, 0);
    bus(1, 4'h0, 8'hA4);
    bus(1, 4'hC, 8'hA1);
    repeat (3) @(posedge ref_clk);
    chk(eraseActive, 0);
    bus(1, 4'hC, 8'h00);
    pins(0, 1, 0);
    ldw(16'h0100, 1);
    erz(8'h10, 8'h00, 1);
    pins(0, 0, 1);
    erz(8'h10, 8'h00, 1);
    pins(1, 0, 0);
    erz(8'h01, 8'h00, 0);
    bus(1, 4'h0, 8'hA5);
    ldw(16'h0100, 1);
    bus(0, 4'h2, 8'h00);
    chk(rd, 0);
    end_of_test;
  end
endmodule // fbsec_ctrl_tb_top
